// ==== core/rbm_pkg.sv ====
// Receive buffer manager package: register map, field layout, carriers.
// Assumes a 32-bit byte-addressed memory behind a single-request port.
package rbm_pkg;

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CFG     = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_QPTR    = 8'h0c;
  localparam logic [7:0] REG_RESERR  = 8'h10;

  localparam int CTRL_RXEN      = 0;
  localparam int CFG_JUMBO      = 3;
  localparam int CFG_OFF_LO     = 14;
  localparam int CFG_NOFCS      = 17;
  localparam int STA_BUFNA      = 0;
  localparam int STA_OVERRUN    = 1;

  // ****************************************
  // Descriptor layout
  // ****************************************
  localparam int DSC_USED       = 0;
  localparam int DSC_WRAP       = 1;
  localparam int DSC_WORD_BYTES = 4;
  localparam int BUF_BYTES      = 128;
  localparam int FCS_BYTES      = 4;
  localparam logic [10:0] DSC_STEP = 11'h002;

  typedef enum {
    S_IDLE, S_FETCH, S_WAIT_ACC, S_DATA, S_STAT, S_USED, S_DROP
  } rbm_state_t;

  // Frame status from the receive path and address filter
  typedef struct packed {
    logic        bcast;
    logic        mcastHash;
    logic        ucastHash;
    logic        extMatch;
    logic [3:0]  specMatch;
    logic        typeIdMatch;
    logic        vlanTag;
    logic        prioTag;
    logic [2:0]  vlanPrio;
    logic        vlan_canonical_format_flag;
    logic [13:0] length;
  } rbm_info_t;

  // Memory request toward the bus master
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rbm_mem_req_t;

endpackage : rbm_pkg

// ==== core/rbm_rx_buffer_manager.sv ====
// Receive buffer descriptor manager: descriptor walk, data and status writes.
// Assumes the memory port answers each request with a one-cycle memDone.
//
// Notes on behaviour
// - VLAN canonical-format flag in status bit 16, only with VLAN bit 21.
// - Bit 15 marks end of frame; otherwise only bits 14:12 valid.
// - Bit 14 marks start of frame; both bits means whole frame.
// - Bits 13:12 carry offset, or length bits 13:12 in jumbo mode.
// - Bits 11:0 carry frame length, FCS included when copied.
// - Frame data entering the FIFO triggers a descriptor fetch.
// - Data writes start only after filter acceptance; errors reclaim.
// - After wrap or 1024th descriptor, fetch from list start.
// - Descriptor address is base plus 11-bit word counter; reads show it.
// - Counter clears after status to wrap descriptor, rolls at 2048 words (1024 descriptors).
// - Consumed buffers get bit zero of word 0 set.
// - Errors reclaim only the current buffer; earlier ones stay used.
// - Used descriptor on fetch sets buffer-not-available and interrupts.
// - Used descriptor during a frame drops it and counts resource error.
// - Late grant or bus error: overrun interrupt, reclaim current buffer.
// - With no-FCS set, FCS not written and length four shorter.
// - Buffers are 128 bytes; first-buffer offset reduces usable length.
// - Descriptor: address word with wrap and used, then status word.
// - Non-final buffers get only start-of-frame and offset status.
// - Final status carries match, tag and VLAN priority bits 31:17.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module rbm_rx_buffer_manager import rbm_pkg::*; #(
  parameter int GNT_LIMIT = 8                  // Cycles allowed for a memory answer
) (
  input  wire logic         clk,               // 10 MHz system clock
  input  wire logic         arst_n,            // Asynchronous reset
  input  wire logic [7:0]   regAddr,           // Register byte address
  input  wire logic [31:0]  regWdata,          // Register write data
  input  wire logic         regWr,             // Write strobe
  input  wire logic         regRd,             // Read strobe
  output logic      [31:0]  regRdata,          // Read data, cycle after strobe
  input  wire logic         rxStart,           // Frame data entering FIFO
  input  wire logic         rxAccept,          // Filter accepts frame
  input  wire logic         rxValid,           // Data word available
  input  wire logic [31:0]  rxWord,            // Data word
  input  wire logic         rxFcsWord,         // Word holds only FCS bytes
  input  wire logic         rxEnd,             // Frame end, info valid
  input  wire rbm_info_t    rxInfo,            // Frame status at end
  input  wire logic         rxError,           // Receive error
  output logic              rxReady,           // Word taken when valid
  output rbm_mem_req_t      mem,               // Memory request
  input  wire logic         memDone,           // Memory answer
  input  wire logic         memErr,            // Bus error on answer
  input  wire logic [31:0]  memRdata,          // Read data with memDone
  output logic              irqBufNa,          // Buffer not available pulse
  output logic              irqOverrun         // Receive overrun pulse
);

  if (GNT_LIMIT < 1 || GNT_LIMIT > 255) begin : g_limitCheck
    $error("GNT_LIMIT out of range");
  end

  // ****************************************
  // Status word assembly
  // ****************************************
  function automatic logic [31:0] makeStatus(input logic fin, input logic sof,
      input logic [1:0] off, input logic jumbo, input rbm_info_t inf,
      input logic [13:0] len);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[14] = sof;
    s[13:12] = off;
    if (fin) begin
      s[31:28] = {inf.bcast, inf.mcastHash, inf.ucastHash, inf.extMatch};
      s[26:20] = {inf.specMatch, inf.typeIdMatch, inf.vlanTag, inf.prioTag};
      s[19:17] = inf.vlanPrio;
      s[16] = inf.vlan_canonical_format_flag & inf.vlanTag;
      s[15] = 1'b1;
      s[13:12] = jumbo ? len[13:12] : off;
      s[11:0] = len[11:0];
    end
    return s;
  endfunction : makeStatus

  // ****************************************
  // Register file
  // ****************************************
  logic        rxEn_reg;
  logic [31:0] cfg_reg;
  logic [31:0] base_reg;
  logic [10:0] cnt_reg;
  logic        staBufNa_reg;
  logic        staOvr_reg;
  logic [31:0] resErr_reg;
  logic        setBufNa;
  logic        setOvr;
  logic        ptrWr;
  logic [31:0] curPtr;

  assign curPtr = base_reg + {19'h0_0000, cnt_reg, 2'h0};
  assign ptrWr  = regWr && regAddr == REG_QPTR;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxEn_reg <= 1'b0;
      cfg_reg  <= 32'h0000_0000;
      base_reg <= 32'h0000_0000;
    end else if (regWr) begin
      if (regAddr == REG_CTRL) rxEn_reg <= regWdata[CTRL_RXEN];
      if (regAddr == REG_CFG) cfg_reg <= regWdata;
      if (ptrWr) base_reg <= {regWdata[31:2], 2'h0};
    end
  end

  // Sticky flags, set wins over write-one-clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      staBufNa_reg <= 1'b0;
      staOvr_reg   <= 1'b0;
    end else begin
      staBufNa_reg <= setBufNa |
        (staBufNa_reg & ~(regWr && regAddr == REG_STATUS && regWdata[STA_BUFNA]));
      staOvr_reg <= setOvr |
        (staOvr_reg & ~(regWr && regAddr == REG_STATUS && regWdata[STA_OVERRUN]));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL:   regRdata <= {31'h0, rxEn_reg};
        REG_CFG:    regRdata <= cfg_reg;
        REG_STATUS: regRdata <= {30'h0, staOvr_reg, staBufNa_reg};
        REG_QPTR:   regRdata <= curPtr;
        REG_RESERR: regRdata <= resErr_reg;
        default:    regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Descriptor walk state machine
  // ****************************************
  rbm_state_t  state_reg;
  logic [31:0] bufAddr_reg;
  logic        wrap_reg;
  logic [7:0]  fill_reg;
  logic        sof_reg;
  logic        final_reg;
  logic        accepted_reg;
  logic        pendEnd_reg;
  logic        pendErr_reg;
  rbm_info_t   info_reg;
  logic [7:0]  wait_reg;
  logic        take;
  logic        full;
  logic        timeout;
  logic        memFail;
  logic        resErrEv;
  logic [1:0]  offCfg;
  logic [13:0] lenAdj;

  assign offCfg  = cfg_reg[CFG_OFF_LO +: 2];
  assign take    = rxValid && rxReady;
  // usable bytes shrink by the offset
  assign full    = 9'(fill_reg) + 9'(DSC_WORD_BYTES) > 9'(BUF_BYTES);
  assign timeout = mem.req && wait_reg == 8'(GNT_LIMIT);
  assign memFail = (memDone && memErr) || timeout;
  // Used descriptor seen on a clean fetch answer
  assign resErrEv = state_reg == S_FETCH && memDone && !memFail && memRdata[DSC_USED];
  assign lenAdj  = cfg_reg[CFG_NOFCS] ? info_reg.length - 14'(FCS_BYTES) : info_reg.length;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 8'h00;
    end else begin
      wait_reg <= (mem.req && !memDone && !timeout) ? wait_reg + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resErr_reg <= 32'h0000_0000;
    end else if (regWr && regAddr == REG_RESERR) begin
      // Drop beside a clear still counts
      resErr_reg <= {31'h0000_0000, resErrEv};
    end else if (resErrEv) begin
      resErr_reg <= resErr_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= S_IDLE;
      mem          <= '0;
      bufAddr_reg  <= 32'h0000_0000;
      wrap_reg     <= 1'b0;
      fill_reg     <= 8'h00;
      sof_reg      <= 1'b0;
      final_reg    <= 1'b0;
      accepted_reg <= 1'b0;
      pendEnd_reg  <= 1'b0;
      pendErr_reg  <= 1'b0;
      info_reg     <= '0;
      cnt_reg      <= 11'h000;
      rxReady      <= 1'b0;
      irqBufNa     <= 1'b0;
      irqOverrun   <= 1'b0;
      setBufNa     <= 1'b0;
      setOvr       <= 1'b0;
    end else begin
      rxReady    <= 1'b0;
      irqBufNa   <= 1'b0;
      irqOverrun <= 1'b0;
      setBufNa   <= 1'b0;
      setOvr     <= 1'b0;
      if (rxAccept) accepted_reg <= 1'b1;
      if (rxEnd) begin
        pendEnd_reg <= 1'b1;
        info_reg    <= rxInfo;
      end
      if (rxError) pendErr_reg <= 1'b1;
      if (ptrWr) cnt_reg <= 11'h000;
      if (memDone || timeout) mem.req <= 1'b0;
      if (memFail && state_reg != S_IDLE && state_reg != S_DROP) begin
        irqOverrun <= 1'b1;
        setOvr     <= 1'b1;
        state_reg  <= final_reg ? S_IDLE : S_DROP;
        if (final_reg) pendEnd_reg <= rxEnd;
      end else begin
        case (state_reg)
          S_IDLE: begin
            accepted_reg <= rxAccept;
            pendEnd_reg  <= 1'b0;
            pendErr_reg  <= 1'b0;
            final_reg    <= 1'b0;
            if (rxEn_reg && rxStart) begin
              sof_reg   <= 1'b1;
              fill_reg  <= 8'(offCfg);
              mem       <= '{req: 1'b1, write: 1'b0, addr: curPtr, wdata: 32'h0};
              state_reg <= S_FETCH;
            end
          end
          S_FETCH: begin
            if (memDone) begin
              if (memRdata[DSC_USED]) begin
                setBufNa  <= 1'b1;
                irqBufNa  <= 1'b1;
                state_reg <= S_DROP;
              end else begin
                bufAddr_reg <= {memRdata[31:2], 2'h0};
                wrap_reg    <= memRdata[DSC_WRAP];
                state_reg   <= S_WAIT_ACC;
              end
            end
          end
          S_WAIT_ACC: begin
            if (pendErr_reg || rxError || (pendEnd_reg && !accepted_reg)) begin
              state_reg <= S_IDLE;
            end else if (accepted_reg) begin
              state_reg <= S_DATA;
            end
          end
          S_DATA: begin
            if (pendErr_reg || rxError) begin
              state_reg <= S_IDLE;
            end else if (!mem.req && !take) begin
              if (pendEnd_reg) begin
                final_reg <= 1'b1;
                mem <= '{req: 1'b1, write: 1'b1, addr: curPtr + 32'(DSC_WORD_BYTES),
                         wdata: makeStatus(1'b1, sof_reg, offCfg, cfg_reg[CFG_JUMBO],
                                           info_reg, lenAdj)};
                state_reg <= S_STAT;
              end else if (full && rxValid) begin
                mem <= '{req: 1'b1, write: 1'b1, addr: curPtr + 32'(DSC_WORD_BYTES),
                         wdata: makeStatus(1'b0, sof_reg, offCfg, cfg_reg[CFG_JUMBO],
                                           info_reg, lenAdj)};
                state_reg <= S_STAT;
              end else begin
                rxReady <= !full && !rxEnd;
              end
            end else if (take) begin
              if (!(rxFcsWord && cfg_reg[CFG_NOFCS])) begin
                mem <= '{req: 1'b1, write: 1'b1,
                         addr: bufAddr_reg + {24'h00_0000, fill_reg[7:2], 2'h0},
                         wdata: rxWord};
                fill_reg <= fill_reg + 8'(DSC_WORD_BYTES);
              end
            end
          end
          S_STAT: begin
            if (memDone) begin
              // mark used, keep wrap and address
              mem <= '{req: 1'b1, write: 1'b1, addr: curPtr,
                       wdata: {bufAddr_reg[31:2], wrap_reg, 1'b1}};
              state_reg <= S_USED;
            end
          end
          S_USED: begin
            if (memDone) begin
              // wrap clears, otherwise step and roll over
              cnt_reg  <= wrap_reg ? 11'h000 : cnt_reg + DSC_STEP;
              sof_reg  <= 1'b0;
              fill_reg <= 8'h00;
              if (final_reg) begin
                state_reg <= S_IDLE;
              end else begin
                mem <= '{req: 1'b1, write: 1'b0,
                         addr: base_reg + {19'h0_0000, wrap_reg ? 11'h000 :
                               cnt_reg + DSC_STEP, 2'h0}, wdata: 32'h0};
                state_reg <= S_FETCH;
              end
            end
          end
          S_DROP: begin
            rxReady <= 1'b1;
            if (pendEnd_reg || pendErr_reg) state_reg <= S_IDLE;
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_used_mark: assert property (state_reg == S_USED && mem.req |-> mem.wdata[0])
    else $error("used bit not set");
  a_final_eof: assert property (state_reg == S_STAT && final_reg |-> mem.wdata[15])
    else $error("final status lacks end bit");
  a_partial_zero: assert property (state_reg == S_STAT && !final_reg
      |-> mem.wdata[31:15] == 17'h0 && mem.wdata[11:0] == 12'h0)
    else $error("partial status not clear");
  a_cfi_gated: assert property (state_reg == S_STAT && !mem.wdata[21] |-> !mem.wdata[16])
    else $error("canonical flag without VLAN");
  a_wrap_reset: assert property (state_reg == S_USED && memDone && !memErr && wrap_reg
      && !ptrWr |=> cnt_reg == 11'h000)
    else $error("counter not cleared on wrap");
  a_bufna_flag: assert property (state_reg == S_FETCH && memDone && !memFail && memRdata[0]
      |=> irqBufNa ##1 (staBufNa_reg && !irqBufNa))
    else $error("buffer not available missed");
  a_drop_count: assert property (state_reg == S_FETCH && memDone && !memFail && memRdata[0]
      && !(regWr && regAddr == REG_RESERR) |=> resErr_reg == $past(resErr_reg) + 1)
    else $error("resource error not counted");
  a_overrun_irq: assert property (memFail && state_reg != S_IDLE && state_reg != S_DROP
      |=> irqOverrun ##1 staOvr_reg)
    else $error("overrun not raised");
  a_data_gate: assert property (state_reg == S_DATA |-> accepted_reg)
    else $error("data before acceptance");

  c_whole_frame: cover property (state_reg == S_STAT && mem.wdata[15] && mem.wdata[14]);
  c_multi_buf: cover property (state_reg == S_STAT && !final_reg);
  c_wrap_taken: cover property (state_reg == S_USED && memDone && wrap_reg);
  c_buf_na: cover property (irqBufNa);

endmodule : rbm_rx_buffer_manager

// ==== bench/rbm_mem_model.sv ====
// Memory responder standing behind the memory port of the receive buffer manager.
// Assumes one outstanding request; backdoor access to ram, delay, errWrite and mute.
`timescale 1ns/10ps
module rbm_mem_model import rbm_pkg::*; (
  input  wire logic         clk,      // System clock
  input  wire logic         arst_n,   // Asynchronous reset
  input  wire rbm_mem_req_t mem,      // Request from device
  output logic              memDone,  // Answer pulse
  output logic              memErr,   // Bus error with answer
  output logic      [31:0]  memRdata  // Read data with answer
);
  logic [31:0] ram [4096];
  int          delay    = 1;
  logic        errWrite = 1'b0;
  logic        mute     = 1'b0;
  int          cnt;

  // ****************************************
  // Answer engine
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memDone  <= 1'b0;
      memErr   <= 1'b0;
      memRdata <= 32'h0;
      cnt      <= 0;
    end else if (memDone || !mem.req || mute) begin
      memDone  <= 1'b0;
      memErr   <= 1'b0;
      memRdata <= ~memRdata;
      cnt      <= 0;
    end else if (cnt < delay) begin
      memRdata <= ~memRdata;
      cnt      <= cnt + 1;
    end else begin
      cnt      <= 0;
      memDone  <= 1'b1;
      memRdata <= ram[mem.addr[13:2]];
      memErr   <= mem.write && errWrite;
      if (mem.write && errWrite) begin
        errWrite <= 1'b0;
      end else if (mem.write) begin
        ram[mem.addr[13:2]] <= mem.wdata;
      end
    end
  end
endmodule : rbm_mem_model

// ==== bench/testbench.sv ====
// Testbench for the receive buffer manager: register tasks, frame tasks, memory model.
// Assumes the memory model is reachable by hierarchical name for descriptor setup.
`timescale 1ns/10ps
module testbench import rbm_pkg::*; ;
  localparam logic [31:0] BASE = 32'h0000_0100;
  localparam logic [31:0] BUFS = 32'h0000_3000;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  logic [7:0]   regAddr = 8'h00;
  logic [31:0]  regWdata = 32'h0;
  logic         regWr = 1'b0;
  logic         regRd = 1'b0;
  logic [31:0]  regRdata;
  logic         rxStart = 1'b0;
  logic         rxAccept = 1'b0;
  logic         rxValid = 1'b0;
  logic [31:0]  rxWord = 32'h0;
  logic         rxFcsWord = 1'b0;
  logic         rxEnd = 1'b0;
  rbm_info_t    rxInfo = '0;
  logic         rxError = 1'b0;
  logic         rxReady;
  rbm_mem_req_t mem;
  logic         memDone;
  logic         memErr;
  logic [31:0]  memRdata;
  logic         irqBufNa;
  logic         irqOverrun;
  logic [31:0]  rd;
  int           miscompares = 0;
  int           cmp_count = 0;
  int           nBufNa = 0;
  int           nOvr = 0;

  always #50 clk = ~clk;

  rbm_rx_buffer_manager u_rbm_rx_buffer_manager (.clk(clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rxStart(rxStart), .rxAccept(rxAccept), .rxValid(rxValid),
    .rxWord(rxWord), .rxFcsWord(rxFcsWord), .rxEnd(rxEnd), .rxInfo(rxInfo),
    .rxError(rxError), .rxReady(rxReady), .mem(mem), .memDone(memDone), .memErr(memErr),
    .memRdata(memRdata), .irqBufNa(irqBufNa), .irqOverrun(irqOverrun));
  rbm_mem_model u_mem (.clk(clk), .arst_n(arst_n), .mem(mem), .memDone(memDone),
    .memErr(memErr), .memRdata(memRdata));

  always @(posedge clk) begin
    if (irqBufNa === 1'b1) nBufNa++;
    if (irqOverrun === 1'b1) nOvr++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask : regRead

  function automatic int di(input int k);
    return int'(BASE >> 2) + 2 * k;
  endfunction : di

  task automatic setDesc(input int k, input logic [31:0] ba, input logic wrap);
    u_mem.ram[di(k)] = ba | {30'h0, wrap, 1'b0};
    u_mem.ram[di(k) + 1] = 32'h0;
  endtask : setDesc

  task automatic frame(input int n, input rbm_info_t inf, input logic fcs, input int errAt,
                       input logic preAcc);
    int t;
    int i = 0;
    @(posedge clk);
    rxStart <= 1'b1;
    @(posedge clk);
    rxStart   <= 1'b0;
    rxValid   <= 1'b1;
    rxWord    <= 32'ha500_0000;
    rxFcsWord <= fcs && n == 1;
    repeat (4) begin
      @(posedge clk);
      if (preAcc) check("ready before accept", {31'h0, rxReady}, 32'h0);
    end
    rxAccept <= 1'b1;
    @(posedge clk);
    rxAccept <= 1'b0;
    while (i < n && i != errAt) begin
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (rxReady !== 1'b1 && t < 100);
      if (t >= 100) check("word taken", 32'h0, 32'h1);
      i++;
      rxWord    <= 32'ha500_0000 + 32'(i);
      rxFcsWord <= fcs && i == n - 1;
    end
    rxValid <= 1'b0;
    if (errAt < 0) begin
      rxEnd  <= 1'b1;
      rxInfo <= inf;
    end else rxError <= 1'b1;
    @(posedge clk);
    rxEnd   <= 1'b0;
    rxError <= 1'b0;
    t = 0;
    i = 0;
    while (i < 6 && t < 400) begin
      @(posedge clk);
      t++;
      i = mem.req ? 0 : i + 1;
    end
    if (i < 6) check("frame idle", 32'h0, 32'h1);
  endtask : frame

  function automatic logic [31:0] stat(rbm_info_t f, logic sof, logic eof, logic [1:0] off,
                                       logic jumbo, logic nofcs);
    logic [13:0] len;
    len = f.length - (nofcs ? 14'h4 : 14'h0);
    if (!eof) return {16'h0, 1'b0, sof, off, 12'h0};
    return {f[28:25], 1'b0, f[24:14], eof, sof, jumbo ? len[13:12] : off, len[11:0]};
  endfunction : stat

  task automatic chkFrame(input int k, input int n, input int first, input logic [31:0] st);
    logic [31:0] ba;
    ba = BUFS + 32'h80 * 32'(k);
    for (int i = 0; i < n; i++)
      check("data", u_mem.ram[ba[13:2] + i], 32'ha500_0000 + 32'(first + i));
    check("word0", u_mem.ram[di(k)], ba | 32'h1 | (k == 3 ? 32'h2 : 32'h0));
    check("status", u_mem.ram[di(k) + 1], st);
  endtask : chkFrame

  task automatic chkPtr(input int k);
    regRead(REG_QPTR, rd);
    check("queue pointer", rd, BASE + 32'(8 * k));
  endtask : chkPtr

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rbm_info_t inf;
    inf = '{bcast: 1'b1, specMatch: 4'ha, vlanTag: 1'b1, vlanPrio: 3'h5,
            vlan_canonical_format_flag: 1'b1, length: 14'h00c, default: '0};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    regWrite(REG_QPTR, BASE);
    chkPtr(0);
    regRead(8'h14, rd);
    check("unmapped read", rd, 32'h0);
    for (int k = 0; k < 4; k++) setDesc(k, BUFS + 32'h80 * 32'(k), k == 3);
    u_mem.ram[(BUFS >> 2) + 66] = 32'hdead_beef;
    regWrite(REG_CTRL, 32'h1);
    regWrite(REG_CFG, 32'h0000_8000);
    frame(3, inf, 1'b0, -1, 1'b1);
    chkFrame(0, 3, 0, stat(inf, 1'b1, 1'b1, 2'h2, 1'b0, 1'b0));
    $display("test single frame done");
    u_mem.delay = 3;
    regWrite(REG_CFG, 32'h0000_4008);
    inf.length = 14'h3004;
    frame(2, inf, 1'b0, -1, 1'b1);
    chkFrame(1, 2, 0, stat(inf, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0));
    $display("test jumbo done");
    u_mem.delay = 0;
    regWrite(REG_CFG, 32'h0002_0000);
    inf.length = 14'h00c;
    frame(3, inf, 1'b1, -1, 1'b1);
    chkFrame(2, 2, 0, stat(inf, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1));
    check("fcs not stored", u_mem.ram[(BUFS >> 2) + 66], 32'hdead_beef);
    $display("test fcs strip done");
    regWrite(REG_CFG, 32'h0);
    setDesc(0, BUFS, 1'b0);
    inf.length = 14'h088;
    frame(34, inf, 1'b0, -1, 1'b1);
    chkFrame(3, 32, 0, stat(inf, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
    chkFrame(0, 2, 32, stat(inf, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0));
    chkPtr(1);
    $display("test multi buffer wrap done");
    frame(2, inf, 1'b0, -1, 1'b0);
    check("bufna irq", 32'(nBufNa), 32'h1);
    regRead(REG_STATUS, rd);
    check("bufna flag", rd, 32'h1);
    regRead(REG_RESERR, rd);
    check("resource errors", rd, 32'h1);
    regWrite(REG_STATUS, 32'h3);
    $display("test used descriptor done");
    setDesc(1, BUFS + 32'h80, 1'b0);
    u_mem.errWrite = 1'b1;
    inf.length = 14'h008;
    frame(2, inf, 1'b0, -1, 1'b1);
    check("overrun irq", 32'(nOvr), 32'h1);
    check("reclaimed word0", u_mem.ram[di(1)], BUFS + 32'h80);
    regRead(REG_STATUS, rd);
    check("overrun flag", rd, 32'h2);
    frame(2, inf, 1'b0, -1, 1'b1);
    chkFrame(1, 2, 0, stat(inf, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0));
    chkPtr(2);
    $display("test bus error done");
    setDesc(2, BUFS + 32'h100, 1'b0);
    setDesc(3, BUFS + 32'h180, 1'b1);
    frame(34, inf, 1'b0, 33, 1'b1);
    check("earlier kept", u_mem.ram[di(2)], BUFS + 32'h101);
    check("current reclaimed", u_mem.ram[di(3)], BUFS + 32'h182);
    check("fragment", u_mem.ram[di(2) + 1], stat(inf, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
    chkPtr(3);
    $display("test receive error done");
    u_mem.mute = 1'b1;
    frame(1, inf, 1'b0, -1, 1'b0);
    u_mem.mute = 1'b0;
    check("late grant overrun", 32'(nOvr), 32'h2);
    $display("test late grant done");
    regWrite(REG_QPTR, BASE);
    for (int k = 0; k < 1024; k++) setDesc(k, BUFS + 32'h280, 1'b0);
    for (int k = 0; k < 1024; k++) frame(1, inf, 1'b0, -1, 1'b0);
    chkPtr(0);
    $display("test rollover done");
    conclude();
  end

  initial begin
    #(60000 * 100);
    miscompares++;
    conclude();
  end
endmodule : testbench
